// file: rtl/csms_regs.vh
/*
 * Register offsets, field positions, reset values and encodings of the
 * clock source and mode select block.
 * Assumes a 32-bit AXI4-Lite slave with one aligned word per register.
 */
`ifndef CSMS_REGS_VH
`define CSMS_REGS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CSMS_OFS_SELECT     4'h0
`define CSMS_OFS_RANGE      4'h4
`define CSMS_OFS_TRIM       4'h8
`define CSMS_OFS_STATUS     4'hC
`define CSMS_ADDR_W         4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CSMS_SELECT_RST     8'h04
`define CSMS_RANGE_RST      8'h40
`define CSMS_TRIM_RST       8'h80

// ----------------------------------------------------------------------
// Select control fields
// ----------------------------------------------------------------------
`define CSMS_SRC_HI         7
`define CSMS_SRC_LO         6
`define CSMS_REFERENCE_DIVIDER_HI        5
`define CSMS_REFERENCE_DIVIDER_LO        3
`define CSMS_LOOP_REFERENCE_SELECT_BIT      2
`define CSMS_INTERNAL_REF_OUTPUT_ENABLE_BIT    1
`define CSMS_INTERNAL_REF_STOP_KEEP_BIT   0

// ----------------------------------------------------------------------
// Range control fields
// ----------------------------------------------------------------------
`define CSMS_BUS_DIVIDER_HI        7
`define CSMS_BUS_DIVIDER_LO        6
`define CSMS_LP_BIT         3
`define CSMS_ERCLKEN_BIT    1
`define CSMS_EREFSTEN_BIT   0

// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define CSMS_ST_IREF_BIT    4
`define CSMS_ST_SRC_HI      3
`define CSMS_ST_SRC_LO      2
`define CSMS_ST_LOOP_BIT    1

// ----------------------------------------------------------------------
// Clock source encodings
// ----------------------------------------------------------------------
`define CSMS_SRC_LOOP       2'h0
`define CSMS_SRC_INT        2'h1
`define CSMS_SRC_EXT        2'h2
`define CSMS_SRC_RSVD       2'h3

// ----------------------------------------------------------------------
// Divider widths and fixed shifts
// ----------------------------------------------------------------------
`define CSMS_SHIFT_W        3
`define CSMS_CNT_W          7
`define CSMS_SHIFT_HALF     3'h1

// ----------------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------------
`define CSMS_RESP_OKAY      2'h0
`define CSMS_RESP_SLVERR    2'h2

`endif

// file: rtl/csms_pdiv.v
/*
 * Power-of-two divider of a tick stream: passes one tick in 2**shift.
 * Assumes tick_in is a one-cycle enable synchronous to aclk.
 */
`timescale 1ns/1ps
`include "csms_regs.vh"

module csms_pdiv (
    aclk,
    aresetn,
    run,
    tick_in,
    shift,
    tick_out
);
    input  wire                      aclk;
    input  wire                      aresetn;
    input  wire                      run;
    input  wire                      tick_in;
    input  wire [`CSMS_SHIFT_W-1:0]  shift;
    output reg                       tick_out;

    reg  [`CSMS_CNT_W-1:0] cnt_reg;
    wire [`CSMS_CNT_W-1:0] mask;

    // ------------------------------------------------------------------
    // Divide
    // ------------------------------------------------------------------
    // Mask of the low counter bits that must all be set for a pass
    assign mask = ~({`CSMS_CNT_W{1'b1}} << shift);

    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg  <= {`CSMS_CNT_W{1'b0}};
            tick_out <= 1'b0;
        end else if (!run) begin
            // Restart cleanly so a new ratio takes effect from zero
            cnt_reg  <= {`CSMS_CNT_W{1'b0}};
            tick_out <= 1'b0;
        end else begin
            tick_out <= tick_in && ((cnt_reg & mask) == mask);
            if (tick_in) begin
                cnt_reg <= cnt_reg + {{(`CSMS_CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule

// file: rtl/csms_top.v
/*
 * Clock source and mode select: source choice, reference divider,
 * bus divider, loop enable and stop handling, with AXI4-Lite registers.
 * Assumes ticks, stop and debug levels all synchronous to aclk.
 */
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "csms_regs.vh"

module csms_top (
    aclk,
    aresetn,
    s_axi_awaddr,
    s_axi_awvalid,
    s_axi_awready,
    s_axi_wdata,
    s_axi_wstrb,
    s_axi_wvalid,
    s_axi_wready,
    s_axi_bresp,
    s_axi_bvalid,
    s_axi_bready,
    s_axi_araddr,
    s_axi_arvalid,
    s_axi_arready,
    s_axi_rdata,
    s_axi_rresp,
    s_axi_rvalid,
    s_axi_rready,
    loop_tick,
    internal_ref_tick,
    external_ref_tick,
    stop_mode,
    background_debug_active,
    loop_reference_tick,
    loop_enable,
    clock_unit_output,
    bus_clock_tick,
    background_debug_clock,
    internal_ref_clock_out,
    internal_ref_running,
    external_ref_running,
    trim_value
);
    input  wire        aclk;
    input  wire        aresetn;
    input  wire [31:0] s_axi_awaddr;
    input  wire        s_axi_awvalid;
    output wire        s_axi_awready;
    input  wire [31:0] s_axi_wdata;
    input  wire [3:0]  s_axi_wstrb;
    input  wire        s_axi_wvalid;
    output wire        s_axi_wready;
    output reg  [1:0]  s_axi_bresp;
    output reg         s_axi_bvalid;
    input  wire        s_axi_bready;
    input  wire [31:0] s_axi_araddr;
    input  wire        s_axi_arvalid;
    output wire        s_axi_arready;
    output reg  [31:0] s_axi_rdata;
    output reg  [1:0]  s_axi_rresp;
    output reg         s_axi_rvalid;
    input  wire        s_axi_rready;
    input  wire        loop_tick;
    input  wire        internal_ref_tick;
    input  wire        external_ref_tick;
    input  wire        stop_mode;
    input  wire        background_debug_active;
    output wire        loop_reference_tick;
    output reg         loop_enable;
    output reg         clock_unit_output;
    output wire        bus_clock_tick;
    output reg         background_debug_clock;
    output reg         internal_ref_clock_out;
    output reg         internal_ref_running;
    output reg         external_ref_running;
    output wire [7:0]  trim_value;

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    // Returns {hit, index} for a byte address
    function [2:0] csms_decode;
        input [31:0] addr;
        begin
            case (addr[`CSMS_ADDR_W-1:0])
                `CSMS_OFS_SELECT: csms_decode = 3'h4;
                `CSMS_OFS_RANGE:  csms_decode = 3'h5;
                `CSMS_OFS_TRIM:   csms_decode = 3'h6;
                `CSMS_OFS_STATUS: csms_decode = 3'h7;
                default:          csms_decode = 3'h0;
            endcase
            if (|addr[31:`CSMS_ADDR_W]) begin
                csms_decode = 3'h0;
            end
        end
    endfunction

    // Effective source: the reserved code folds onto the loop output
    function [1:0] csms_source;
        input [1:0] field;
        begin
            case (field)
                `CSMS_SRC_INT: csms_source = `CSMS_SRC_INT;
                `CSMS_SRC_EXT: csms_source = `CSMS_SRC_EXT;
                `CSMS_SRC_LOOP: csms_source = `CSMS_SRC_LOOP;
                default:       csms_source = `CSMS_SRC_LOOP;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    reg  [7:0]  select_reg;
    reg  [7:0]  range_reg;
    reg  [7:0]  trim_reg;
    reg  [31:0] awaddr_reg;
    reg         aw_held_reg;
    reg  [7:0]  wdata_reg;
    reg         wlane_reg;
    reg         w_held_reg;
    reg         was_internal_reg;
    reg         was_external_reg;
    reg  [2:0]  wsel;
    reg  [2:0]  rsel;
    reg  [31:0] rword;

    wire [7:0]  status_word;

    assign trim_value = trim_reg;

    // ------------------------------------------------------------------
    // AXI write channel
    // ------------------------------------------------------------------
    // Address and data are caught separately; the write lands when both
    // are held and no response is still waiting.
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;

    always @* begin
        wsel = csms_decode(awaddr_reg);
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            awaddr_reg   <= 32'h00000000;
            aw_held_reg  <= 1'b0;
            wdata_reg    <= 8'h00;
            wlane_reg    <= 1'b0;
            w_held_reg   <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `CSMS_RESP_OKAY;
            select_reg   <= `CSMS_SELECT_RST;
            range_reg    <= `CSMS_RANGE_RST;
            trim_reg     <= `CSMS_TRIM_RST;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_reg  <= s_axi_awaddr;
                aw_held_reg <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_reg  <= s_axi_wdata[7:0];
                wlane_reg  <= s_axi_wstrb[0];
                w_held_reg <= 1'b1;
            end
            if (aw_held_reg && w_held_reg) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wsel[2] ? `CSMS_RESP_OKAY
                                        : `CSMS_RESP_SLVERR;
                // Only byte lane 0 carries register bits
                if (wlane_reg) begin
                    case (wsel)
                        3'h4:    select_reg <= wdata_reg;
                        3'h5:    range_reg  <= wdata_reg;
                        3'h6:    trim_reg   <= wdata_reg;
                        default: select_reg <= select_reg;
                    endcase
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // AXI read channel
    // ------------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;

    always @* begin
        rsel  = csms_decode(s_axi_araddr);
        rword = 32'h00000000;
        case (rsel)
            3'h4:    rword[7:0] = select_reg;
            3'h5:    rword[7:0] = range_reg;
            3'h6:    rword[7:0] = trim_reg;
            3'h7:    rword[7:0] = status_word;
            default: rword      = 32'h00000000;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `CSMS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rword;
            s_axi_rresp  <= rsel[2] ? `CSMS_RESP_OKAY : `CSMS_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    wire [1:0] source;
    wire       iref_sel;
    wire       bypassed;
    wire       lp_bit;
    wire       ext_lp_bypass;
    wire       int_lp_bypass;
    wire       int_mode;
    wire       ext_mode;
    wire       loop_on;
    wire       keep_int;
    wire       keep_ext;

    assign source   = csms_source(select_reg[`CSMS_SRC_HI:`CSMS_SRC_LO]);
    assign iref_sel = select_reg[`CSMS_LOOP_REFERENCE_SELECT_BIT];
    assign lp_bit   = range_reg[`CSMS_LP_BIT];
    assign bypassed = (source != `CSMS_SRC_LOOP);
    assign ext_lp_bypass = (source == `CSMS_SRC_EXT) && lp_bit;
    assign int_lp_bypass = (source == `CSMS_SRC_INT) && lp_bit;
    // Internal modes: loop on internal reference, or bypassed onto it
    assign int_mode = (!bypassed && iref_sel) || (source == `CSMS_SRC_INT);
    assign ext_mode = (!bypassed && !iref_sel) || (source == `CSMS_SRC_EXT);

    assign loop_on = !stop_mode &&
        !(bypassed && lp_bit && !background_debug_active);

    // Mode before stop decides which reference stays alive
    always @(posedge aclk) begin
        if (!aresetn) begin
            was_internal_reg <= 1'b1;
            was_external_reg <= 1'b0;
        end else if (!stop_mode) begin
            was_internal_reg <= int_mode;
            was_external_reg <= ext_mode;
        end
    end

    assign keep_int = select_reg[`CSMS_INTERNAL_REF_STOP_KEEP_BIT] &&
        (select_reg[`CSMS_INTERNAL_REF_OUTPUT_ENABLE_BIT] || was_internal_reg);
    assign keep_ext = range_reg[`CSMS_EREFSTEN_BIT]
                      && (range_reg[`CSMS_ERCLKEN_BIT] || was_external_reg);

    // ------------------------------------------------------------------
    // Reference path to the loop
    // ------------------------------------------------------------------
    wire ref_tick;

    assign ref_tick = iref_sel ? internal_ref_tick : external_ref_tick;

    csms_pdiv u_ref_div (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .run      (loop_on),
        .tick_in  (ref_tick),
        .shift    (select_reg[`CSMS_REFERENCE_DIVIDER_HI:`CSMS_REFERENCE_DIVIDER_LO]),
        .tick_out (loop_reference_tick)
    );

    // ------------------------------------------------------------------
    // Source select and bus divider
    // ------------------------------------------------------------------
    reg        src_tick;
    wire       div_tick;
    wire [2:0] bus_shift;

    always @* begin
        case (source)
            `CSMS_SRC_INT: src_tick = internal_ref_tick;
            `CSMS_SRC_EXT: src_tick = external_ref_tick;
            default:       src_tick = loop_tick && loop_on;
        endcase
    end

    // Two-bit code widened to a shift of 0 to 3
    assign bus_shift = {1'b0, range_reg[`CSMS_BUS_DIVIDER_HI:`CSMS_BUS_DIVIDER_LO]};

    csms_pdiv u_bus_div (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .run      (!stop_mode),
        .tick_in  (src_tick),
        .shift    (bus_shift),
        .tick_out (div_tick)
    );

    csms_pdiv u_half_div (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .run      (!stop_mode),
        .tick_in  (div_tick),
        .shift    (`CSMS_SHIFT_HALF),
        .tick_out (bus_clock_tick)
    );

    // ------------------------------------------------------------------
    // Registered clock and level outputs
    // ------------------------------------------------------------------
    reg dbg_phase_reg;

    always @(posedge aclk) begin
        if (!aresetn) begin
            loop_enable            <= 1'b0;
            clock_unit_output      <= 1'b0;
            background_debug_clock <= 1'b0;
            internal_ref_clock_out <= 1'b0;
            internal_ref_running   <= 1'b0;
            external_ref_running   <= 1'b0;
            dbg_phase_reg          <= 1'b0;
        end else begin
            loop_enable       <= loop_on;
            clock_unit_output <= div_tick && !stop_mode;
            // Debug clock is a fixed half of the loop output; it is absent
            // in the low-power bypasses even when debug holds the loop up
            if (loop_tick && loop_on) begin
                dbg_phase_reg <= !dbg_phase_reg;
            end
            background_debug_clock <= loop_tick && loop_on && dbg_phase_reg
                                      && !ext_lp_bypass
                                      && !int_lp_bypass;
            internal_ref_running <= !stop_mode || keep_int;
            external_ref_running <= !stop_mode || keep_ext;
            internal_ref_clock_out <= internal_ref_tick
                                      && select_reg[`CSMS_INTERNAL_REF_OUTPUT_ENABLE_BIT]
                                      && (!stop_mode || keep_int);
        end
    end

    // ------------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------------
    assign status_word = {3'h0, iref_sel, source, loop_on, 1'b0};

endmodule

// file: verif/csms_top_sva.sv
/*
 * Checker of bus handshakes and clock gating at the csms_top ports.
 * Assumes one clock domain and a synchronous low-active reset.
 */
`timescale 1ns/1ps

module csms_sva (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        stop_mode,
    input wire logic        loop_enable,
    input wire logic        clock_unit_output,
    input wire logic        bus_clock_tick,
    input wire logic        background_debug_clock
);
    // ------------------------------------------------------------------
    // Defaults
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    a_write_refused: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready)
        else $error("write ready during response");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read ready during read data");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid)
        else $error("read data late");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");

    // ------------------------------------------------------------------
    // Clock gating; ticks may flush for a few cycles after stop
    // ------------------------------------------------------------------
    a_stop_silent: assert property (
        stop_mode [*4] |-> !clock_unit_output && !bus_clock_tick &&
        !background_debug_clock)
        else $error("clock tick while stopped");
    a_stop_loop: assert property (stop_mode |=> !loop_enable)
        else $error("loop running while stopped");
    a_bus_half: assert property (bus_clock_tick |=> !bus_clock_tick)
        else $error("bus tick twice in a row");
endmodule

bind csms_top csms_sva u_sva (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .stop_mode(stop_mode), .loop_enable(loop_enable),
    .clock_unit_output(clock_unit_output),
    .bus_clock_tick(bus_clock_tick),
    .background_debug_clock(background_debug_clock)
);

// file: verif/test_csms_top.sv
/*
 * Self-checking bench of csms_top: registers over AXI4-Lite, tick counts.
 * Assumes csms_regs.vh on the include path.
 */
`timescale 1ns/1ps
`include "csms_regs.vh"

module test_csms_top;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    reg          aclk;
    reg          aresetn;
    reg  [31:0]  awaddr;
    reg  [31:0]  wdata;
    reg  [31:0]  araddr;
    reg  [3:0]   wstrb;
    reg          awvalid, wvalid, bready, arvalid, rready;
    reg  [2:0]   tk;
    reg          stop, dbg;
    wire         awready, wready, bvalid, arready, rvalid;
    wire [1:0]   bresp, rresp;
    wire [31:0]  rdata;
    wire         lref, loop_en, cuo, bus_tk, bdc, iro, irun, erun;
    wire [7:0]   trim;
    integer      bad_count, num_checks, seed, i;
    integer      cn [0:4];
    logic [31:0] rv;
    logic [33:0] re;
    logic [1:0]  bq [$];
    logic [33:0] rq [$];

    csms_top u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .loop_tick(tk[0]),
        .internal_ref_tick(tk[1]), .external_ref_tick(tk[2]),
        .stop_mode(stop), .background_debug_active(dbg),
        .loop_reference_tick(lref), .loop_enable(loop_en),
        .clock_unit_output(cuo), .bus_clock_tick(bus_tk),
        .background_debug_clock(bdc), .internal_ref_clock_out(iro),
        .internal_ref_running(irun), .external_ref_running(erun),
        .trim_value(trim)
    );

    // ------------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------------
    task automatic chk_v(input logic [31:0] g, input logic [31:0] e);
        num_checks = num_checks + 1;
        if (g !== e) begin
            bad_count = bad_count + 1;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task close_out;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Each result is held against the oldest note
    always @(posedge aclk) begin
        if (bvalid && bready) begin
            chk_v({30'h0, bresp}, {30'h0, bq.pop_front()});
        end
        if (rvalid && rready) begin
            re = rq.pop_front();
            chk_v(rdata, re[31:0]);
            chk_v({30'h0, rresp}, {30'h0, re[33:32]});
        end
        cn[0] = cn[0] + cuo;
        cn[1] = cn[1] + bus_tk;
        cn[2] = cn[2] + lref;
        cn[3] = cn[3] + iro;
        cn[4] = cn[4] + bdc;
    end

    // ------------------------------------------------------------------
    // Bus master
    // ------------------------------------------------------------------
    task automatic wr(input logic [31:0] a, input logic [7:0] d,
                      input logic [3:0] s, input logic [1:0] r);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        bq.push_back(r);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {24'h000000, d};
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (!aw && awready) begin
                aw = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w && wready) begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, input logic [7:0] d,
                      input logic [1:0] r);
        rq.push_back({r, 24'h000000, d});
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rready  <= 1'b0;
    endtask

    // ------------------------------------------------------------------
    // Tick traffic; 128 ticks keep every divisor up to 128 exact
    // ------------------------------------------------------------------
    task automatic pulses(input logic [2:0] m);
        integer k;
        @(negedge aclk);
        for (k = 0; k < 5; k = k + 1) cn[k] = 0;
        for (k = 0; k < 128; k = k + 1) begin
            @(posedge aclk);
            tk <= m;
            @(posedge aclk);
            tk <= 3'b000;
            if ($random(seed) & 1) @(posedge aclk);
        end
        repeat (5) @(posedge aclk);
        @(negedge aclk);
    endtask

    task automatic scen(input logic [7:0] sl, input logic [7:0] rg,
                        input logic st, input logic db, input logic [2:0] m);
        logic [1:0] src;
        logic       le0, le, wi, we;
        integer     cu;
        src = (sl[7:6] == `CSMS_SRC_RSVD) ? `CSMS_SRC_LOOP : sl[7:6];
        le0 = !(src != 0 && rg[3] && !db);
        le = le0 && !st;
        wi = sl[1] || (src == 0 && sl[2]) || src == 1;
        we = rg[1] || (src == 0 && !sl[2]) || src == 2;
        cu = (st || !m[src]) ? 0 : 128 >> rg[7:6];
        @(posedge aclk);
        stop <= 1'b0;
        dbg  <= db;
        wr(`CSMS_OFS_SELECT, sl, 4'h1, `CSMS_RESP_OKAY);
        wr(`CSMS_OFS_RANGE, rg, 4'h1, `CSMS_RESP_OKAY);
        rd(`CSMS_OFS_STATUS, {3'h0, sl[2], src, le0, 1'b0}, 2'h0);
        stop <= st;
        repeat (4) @(posedge aclk);
        @(negedge aclk);
        chk_v({31'h0, loop_en}, {31'h0, le});
        chk_v({31'h0, irun}, {31'h0, !st || (sl[0] && wi)});
        chk_v({31'h0, erun}, {31'h0, !st || (rg[0] && we)});
        pulses(m);
        chk_v(cn[0], cu);
        chk_v(cn[1], cu / 2);
        chk_v(cn[2], (le && m[2 - sl[2]]) ? 128 >> sl[5:3] : 0);
        chk_v(cn[3], m[1] && sl[1] && (!st || sl[0]) ? 128 : 0);
        chk_v(cn[4], m[0] && le && !(src != 0 && rg[3]) ? 64 : 0);
    endtask

    // ------------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    initial begin
        repeat (30000) @(posedge aclk);
        bad_count = bad_count + 1;
        $display("ERROR %0t: watchdog expired", $time);
        close_out;
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, wdata, araddr, wstrb, tk, stop, dbg} = 0;
        seed = 32'h7c05;
        bad_count = 0;
        num_checks = 0;
        for (i = 0; i < 5; i = i + 1) cn[i] = 0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`CSMS_OFS_SELECT, `CSMS_SELECT_RST, 2'h0);
        rd(`CSMS_OFS_RANGE, `CSMS_RANGE_RST, 2'h0);
        rd(`CSMS_OFS_TRIM, `CSMS_TRIM_RST, 2'h0);
        rd(`CSMS_OFS_STATUS, 8'h12, 2'h0);
        rd(32'h00000010, 8'h00, `CSMS_RESP_SLVERR);
        wr(32'h00000010, 8'hFF, 4'h1, `CSMS_RESP_SLVERR);
        wr(`CSMS_OFS_TRIM, 8'h5A, 4'h1, `CSMS_RESP_OKAY);
        wr(`CSMS_OFS_TRIM, 8'hA5, 4'h0, `CSMS_RESP_OKAY);
        wr(`CSMS_OFS_STATUS, 8'hFF, 4'h1, `CSMS_RESP_OKAY);
        rd(`CSMS_OFS_TRIM, 8'h5A, 2'h0);
        rd(`CSMS_OFS_STATUS, 8'h12, 2'h0);
        chk_v({24'h0, trim}, 32'h0000005A);
        scen(8'h04, 8'h40, 1'b0, 1'b0, 3'b111);
        scen(8'h42, 8'h00, 1'b0, 1'b0, 3'b010);
        scen(8'h80, 8'h08, 1'b0, 1'b0, 3'b101);
        scen(8'h80, 8'h08, 1'b0, 1'b1, 3'b111);
        scen(8'hC4, 8'hC0, 1'b0, 1'b0, 3'b001);
        scen(8'h3C, 8'h80, 1'b0, 1'b0, 3'b110);
        scen(8'h28, 8'h40, 1'b0, 1'b0, 3'b100);
        scen(8'h03, 8'h00, 1'b1, 1'b0, 3'b111);
        scen(8'h06, 8'h03, 1'b1, 1'b0, 3'b111);
        scen(8'h45, 8'h09, 1'b1, 1'b1, 3'b111);
        for (i = 0; i < 4; i = i + 1) begin
            rv = $random(seed);
            scen(rv[7:0], rv[15:8], rv[16], rv[17], rv[20:18]);
        end
        close_out;
    end
endmodule
